// ---- common/ccd_status_pkg.sv ----
`default_nettype none
package ccd_status_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int ROW_W = 12;
  // read offsets per host interface
  localparam logic [7:0] ISA_STATUS_OFS = 8'h06;
  localparam logic [7:0] ISA_MIRROR_OFS = 8'h08;
  localparam logic [7:0] PCI_STATUS_OFS = 8'h08;
  localparam logic [7:0] PCI_MIRROR_OFS = 8'h10;
  // status word bit positions
  localparam int ST_EXPOSE = 0;
  localparam int ST_LINE_DONE = 1;
  localparam int ST_CACHE_OK = 2;
  localparam int ST_TEMP_MIN = 4;
  localparam int ST_TEMP_MAX = 5;
  localparam int ST_SHUTDOWN_DONE = 6;
  localparam int ST_AT_TEMP = 7;
  localparam int ST_GOT_TRIGGER = 10;
  localparam int ST_FRAME_DONE = 11;
  // command word bit used by the status logic
  localparam int CMD_COOLER_SHUTDOWN = 8;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] RD_DATA_RESET = 16'h0000;
  localparam logic [12:0] ROW_COUNT_RESET = 13'h0000;
  // zero in the row field means a full 4096-row frame
  localparam logic [12:0] ROW_FULL_FRAME = 13'h1000;
  localparam logic [2:0] SYNC_RESET = 3'h0;
  // reserved status positions: 15:12, 9, 8 and 3
  localparam logic [15:0] STATUS_RSVD_MASK = 16'hF308;
endpackage
`default_nettype wire

// ---- common/level_sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface level_sync_if;
  logic level;
  logic rise;
  modport src(output level, output rise);
  modport dst(input level, input rise);
endinterface
`default_nettype wire

// ---- rtl/ccd_camera_status_readback.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: status bit 0 follows the exposure-active level from the sequencer.
// R2: host polls status bit 11 while bit 0 is high.
// R3: status bit 1 is set when a line is processed and ready.
// R4: status bit 2 high while cached FIFOs allow the next line readout.
// R5: status bit 4 set when cooler cannot drive temperature higher.
// R6: status bit 5 set when cooler cannot drive temperature lower.
// R7: status bit 6 set when cooler shutdown completes after command bit 8.
// R8: status bit 7 high while sensor sits at the set point.
// R9: host may treat first at-temp high as set point reached.
// R10: status bit 10 set when an external trigger is received.
// R11: status bit 11 set once the programmed number of rows is flushed.
// R12: status bits 3, 8, 9 and 15:12 are reserved, read zero.
// R13: readback register returns the current command register contents.
// R14: low 12 bits of the line-count word give rows to flush.
// R15: readback bits 15..8 keep the command layout, cooler enable downward.
// R16: readback bits 7..0 keep the command layout, shutter enable downward.
module ccd_camera_status_readback
  import ccd_status_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_pci_sel,
  input wire logic i_rd_strobe,
  input wire logic [ADDR_W-1:0] i_rd_addr,
  input wire logic [DATA_W-1:0] i_command_word,
  input wire logic [DATA_W-1:0] i_flush_row_count_word,
  input wire logic i_expose_active,
  input wire logic i_line_done,
  input wire logic i_cache_read_ok,
  input wire logic i_temp_min_limit,
  input wire logic i_temp_max_limit,
  input wire logic i_shutdown_done,
  input wire logic i_at_temp,
  input wire logic i_ext_trigger_pin,
  input wire logic i_row_flushed,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_rd_hit
);
  ////////////////////////////////////////////////////////////////////////////
  level_sync_if trig();

  pin_level_sync u_trig_sync (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_pin(i_ext_trigger_pin),
    .sync(trig.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic line_done;
  logic shutdown_done;
  logic got_trigger;
  logic frame_done;
  logic expose_d;
  logic [12:0] row_count;
  logic next_line_done;
  logic next_shutdown_done;
  logic next_got_trigger;
  logic next_frame_done;
  logic [12:0] next_row_count;
  logic [12:0] row_limit;
  logic status_read;
  logic mirror_read;
  logic [DATA_W-1:0] status_word;

  always_comb
  begin
    status_read = i_rd_strobe &&
      (i_rd_addr == (i_pci_sel ? PCI_STATUS_OFS : ISA_STATUS_OFS));
    mirror_read = i_rd_strobe &&
      (i_rd_addr == (i_pci_sel ? PCI_MIRROR_OFS : ISA_MIRROR_OFS));
  end

  // row target; zero in the field is read as a full 4096-row frame
  always_comb
  begin
    row_limit = {1'b0, i_flush_row_count_word[ROW_W-1:0]}; // [R14]
    if (row_limit == ROW_COUNT_RESET)
    begin
      row_limit = ROW_FULL_FRAME;
    end
  end

  // sticky flags clear on a status read; a new event in that cycle wins
  always_comb
  begin
    next_line_done = (line_done && !status_read) || i_line_done; // [R3]
    next_shutdown_done = (shutdown_done && !status_read) ||
      (i_shutdown_done && i_command_word[CMD_COOLER_SHUTDOWN]); // [R7]
    next_got_trigger = (got_trigger && !status_read) || trig.rise; // [R10]
    next_frame_done = frame_done && !status_read;
    next_row_count = row_count;
    // a new exposure restarts the row tally
    if (i_expose_active && !expose_d)
    begin
      next_row_count = ROW_COUNT_RESET;
    end
    else if (i_row_flushed && row_count != row_limit)
    begin
      next_row_count = row_count + 13'h0001;
      if (next_row_count == row_limit)
      begin
        next_frame_done = 1'b1; // [R11]
      end
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      line_done <= 1'b0;
      shutdown_done <= 1'b0;
      got_trigger <= 1'b0;
      frame_done <= 1'b0;
      expose_d <= 1'b0;
      row_count <= ROW_COUNT_RESET;
    end
    else
    begin
      line_done <= next_line_done;
      shutdown_done <= next_shutdown_done;
      got_trigger <= next_got_trigger;
      frame_done <= next_frame_done;
      expose_d <= i_expose_active;
      row_count <= next_row_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the host sees the poll-time value; R2 and R9 are host habits only
  always_comb
  begin
    status_word = STATUS_RESET; // [R12]
    status_word[ST_EXPOSE] = i_expose_active; // [R1]
    status_word[ST_LINE_DONE] = line_done; // [R3]
    status_word[ST_CACHE_OK] = i_cache_read_ok; // [R4]
    status_word[ST_TEMP_MIN] = i_temp_min_limit; // [R5]
    status_word[ST_TEMP_MAX] = i_temp_max_limit; // [R6]
    status_word[ST_SHUTDOWN_DONE] = shutdown_done; // [R7]
    status_word[ST_AT_TEMP] = i_at_temp; // [R8]
    status_word[ST_GOT_TRIGGER] = got_trigger; // [R10]
    status_word[ST_FRAME_DONE] = frame_done; // [R11]
  end

  logic [DATA_W-1:0] next_rd_data;
  logic next_rd_valid;
  logic next_rd_hit;

  // unmapped reads still answer, with zero data and hit low
  always_comb
  begin
    next_rd_data = RD_DATA_RESET;
    next_rd_valid = i_rd_strobe;
    next_rd_hit = status_read || mirror_read;
    if (status_read)
    begin
      next_rd_data = status_word;
    end
    else if (mirror_read)
    begin
      next_rd_data = i_command_word; // [R13] [R15] [R16]
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_rd_data <= RD_DATA_RESET;
      o_rd_valid <= 1'b0;
      o_rd_hit <= 1'b0;
    end
    else
    begin
      o_rd_data <= next_rd_data;
      o_rd_valid <= next_rd_valid;
      o_rd_hit <= next_rd_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_expose_bit: assert property ( // [R1]
    @(posedge i_core_clk) disable iff (i_srst)
    status_read |=> o_rd_data[ST_EXPOSE] == $past(i_expose_active))
    else $error("expose bit does not follow exposure level");

  a_line_sticky: assert property ( // [R3]
    @(posedge i_core_clk) disable iff (i_srst)
    i_line_done |=> line_done)
    else $error("line done not captured");

  a_cache_bit: assert property ( // [R4]
    @(posedge i_core_clk) disable iff (i_srst)
    status_read ##1 1'b1 |-> o_rd_data[ST_CACHE_OK] == $past(i_cache_read_ok))
    else $error("cache ready bit wrong");

  a_temp_limits: assert property ( // [R5] [R6]
    @(posedge i_core_clk) disable iff (i_srst)
    status_read |=> {o_rd_data[ST_TEMP_MAX], o_rd_data[ST_TEMP_MIN]} ==
      $past({i_temp_max_limit, i_temp_min_limit}))
    else $error("cooler limit bits wrong");

  a_shutdown_gate: assert property ( // [R7]
    @(posedge i_core_clk) disable iff (i_srst)
    !shutdown_done &&
      !(i_shutdown_done && i_command_word[CMD_COOLER_SHUTDOWN])
      |=> !shutdown_done)
    else $error("shutdown done set without command");

  a_at_temp_bit: assert property ( // [R8]
    @(posedge i_core_clk) disable iff (i_srst)
    status_read |=> o_rd_data[ST_AT_TEMP] == $past(i_at_temp))
    else $error("at temperature bit wrong");

  // the flag may only come from a synchronised pin edge, never from noise
  a_trigger_set: assert property ( // [R10]
    @(posedge i_core_clk) disable iff (i_srst)
    !got_trigger && !trig.rise |=> !got_trigger)
    else $error("trigger flag set without a pin edge");

  a_trigger_latency: assert property ( // [R10]
    @(posedge i_core_clk) disable iff (i_srst)
    trig.rise |=> got_trigger)
    else $error("trigger not latched");

  a_frame_count: assert property ( // [R11] [R14]
    @(posedge i_core_clk) disable iff (i_srst)
    $rose(frame_done) |-> row_count == row_limit)
    else $error("frame done before row target");

  a_reserved_zero: assert property ( // [R12]
    @(posedge i_core_clk) disable iff (i_srst)
    $past(status_read) |-> (o_rd_data & STATUS_RSVD_MASK) == 16'h0000)
    else $error("reserved status bits not zero");

  a_mirror_data: assert property ( // [R13] [R15] [R16]
    @(posedge i_core_clk) disable iff (i_srst)
    mirror_read |=> o_rd_data == $past(i_command_word) && o_rd_hit)
    else $error("readback differs from command word");
endmodule
`default_nettype wire

// ---- rtl/pin_level_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_level_sync
  import ccd_status_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_pin,
  level_sync_if.src sync
);
  logic [2:0] stage;
  logic level;
  logic rise;
  logic [2:0] next_stage;
  logic next_level;
  logic next_rise;

  // stage[0] feeds stage[1] only; the level moves once stages 1 and 2 agree
  always_comb
  begin
    next_stage = {stage[1:0], i_pin};
    next_level = level;
    if (stage[1] == stage[2])
    begin
      next_level = stage[2];
    end
    next_rise = next_level && !level;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      stage <= SYNC_RESET;
      level <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      stage <= next_stage;
      level <= next_level;
      rise <= next_rise;
    end
  end

  assign sync.level = level;
  assign sync.rise = rise;

  a_rise_one_cycle: assert property ( // [R10]
    @(posedge i_core_clk) disable iff (i_srst)
    rise |-> level && !$past(level) ##1 !rise)
    else $error("trigger rise pulse malformed");
endmodule
`default_nettype wire

// ---- sim/host_poll_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_poll_model
(
  input wire logic i_core_clk,
  input wire logic i_rd_valid,
  input wire logic i_rd_hit,
  input wire logic [15:0] i_rd_data,
  output logic o_rd_strobe,
  output logic [7:0] o_rd_addr
);
  initial
  begin
    o_rd_strobe = 1'b0;
    o_rd_addr = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // answer is read at the edge, before that edge's own updates land
  task automatic rd(input logic [7:0] a, output logic [16:0] r,
                    output logic ok);
    ok = 1'b0;
    r = 17'h00000;
    @(posedge i_core_clk);
    o_rd_strobe <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_core_clk);
    o_rd_strobe <= 1'b0;
    o_rd_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge i_core_clk);
      if (i_rd_valid === 1'b1)
      begin
        ok = 1'b1;
        r = {i_rd_hit, i_rd_data};
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_ccd_camera_status_readback.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_ccd_camera_status_readback
  import ccd_status_pkg::*;
  ;
  logic i_core_clk, i_srst, i_pci_sel, i_rd_strobe;
  logic [ADDR_W-1:0] i_rd_addr;
  logic [DATA_W-1:0] i_command_word, i_flush_row_count_word, o_rd_data;
  logic i_expose_active, i_line_done, i_cache_read_ok, i_temp_min_limit;
  logic i_temp_max_limit, i_shutdown_done, i_at_temp, i_ext_trigger_pin;
  logic i_row_flushed, o_rd_valid, o_rd_hit;
  int err_count = 0;
  int samples_checked = 0;

  initial i_core_clk = 1'b0;
  always #2.5 i_core_clk = ~i_core_clk;

  ccd_camera_status_readback u_ccd_camera_status_readback (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_pci_sel(i_pci_sel),
    .i_rd_strobe(i_rd_strobe),
    .i_rd_addr(i_rd_addr),
    .i_command_word(i_command_word),
    .i_flush_row_count_word(i_flush_row_count_word),
    .i_expose_active(i_expose_active),
    .i_line_done(i_line_done),
    .i_cache_read_ok(i_cache_read_ok),
    .i_temp_min_limit(i_temp_min_limit),
    .i_temp_max_limit(i_temp_max_limit),
    .i_shutdown_done(i_shutdown_done),
    .i_at_temp(i_at_temp),
    .i_ext_trigger_pin(i_ext_trigger_pin),
    .i_row_flushed(i_row_flushed),
    .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid),
    .o_rd_hit(o_rd_hit)
  );
  host_poll_model u_host_poll_model (.i_core_clk(i_core_clk),
    .i_rd_valid(o_rd_valid), .i_rd_hit(o_rd_hit), .i_rd_data(o_rd_data),
    .o_rd_strobe(i_rd_strobe), .o_rd_addr(i_rd_addr));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic expect_rd(input logic [7:0] a, input logic [16:0] exp);
    logic [16:0] r;
    logic ok;
    u_host_poll_model.rd(a, r, ok);
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t no answer to read %h", $time, a);
      tally_and_finish();
    end
    else
    begin
      check(r, exp);
    end
  endtask

  task automatic pulse(input int k);
    @(posedge i_core_clk);
    case (k)
      0: i_line_done <= 1'b1;
      1: i_shutdown_done <= 1'b1;
      default: i_row_flushed <= 1'b1;
    endcase
    @(posedge i_core_clk);
    i_line_done <= 1'b0;
    i_shutdown_done <= 1'b0;
    i_row_flushed <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_map();
    expect_rd(ISA_STATUS_OFS, 17'h10000);
    expect_rd(8'h04, 17'h00000);
    i_pci_sel <= 1'b1;
    expect_rd(8'h06, 17'h00000);
    i_pci_sel <= 1'b0;
    $display("test reset_map done");
  endtask

  task automatic t_levels();
    i_expose_active <= 1'b1;
    i_cache_read_ok <= 1'b1;
    i_temp_min_limit <= 1'b1;
    i_temp_max_limit <= 1'b1;
    i_at_temp <= 1'b1;
    // the host may keep this first at-temp sighting as set point reached
    expect_rd(ISA_STATUS_OFS, 17'h100B5);
    i_at_temp <= 1'b0;
    i_cache_read_ok <= 1'b0;
    i_temp_max_limit <= 1'b0;
    expect_rd(ISA_STATUS_OFS, 17'h10011);
    i_expose_active <= 1'b0;
    i_temp_min_limit <= 1'b0;
    expect_rd(ISA_STATUS_OFS, 17'h10000);
    $display("test levels done");
  endtask

  task automatic t_mirror();
    i_command_word <= 16'hA5C3;
    expect_rd(ISA_MIRROR_OFS, 17'h1A5C3);
    i_pci_sel <= 1'b1;
    i_command_word <= 16'h5A3C;
    expect_rd(PCI_MIRROR_OFS, 17'h15A3C);
    expect_rd(PCI_STATUS_OFS, 17'h10000);
    i_pci_sel <= 1'b0;
    $display("test mirror done");
  endtask

  task automatic t_sticky();
    i_command_word <= 16'h0000;
    pulse(1);
    pulse(0);
    expect_rd(ISA_STATUS_OFS, 17'h10002);
    expect_rd(ISA_STATUS_OFS, 17'h10000);
    i_command_word <= 16'h0100;
    pulse(1);
    expect_rd(ISA_STATUS_OFS, 17'h10040);
    // pin held long enough to pass the synchroniser
    i_ext_trigger_pin <= 1'b1;
    repeat (8) @(posedge i_core_clk);
    i_ext_trigger_pin <= 1'b0;
    expect_rd(ISA_STATUS_OFS, 17'h10400);
    $display("test sticky done");
  endtask

  task automatic t_frame();
    // mode nibble set so only the low 12 bits may count
    i_flush_row_count_word <= 16'hF003;
    i_expose_active <= 1'b1;
    pulse(2);
    pulse(2);
    expect_rd(ISA_STATUS_OFS, 17'h10001);
    pulse(2);
    expect_rd(ISA_STATUS_OFS, 17'h10801);
    expect_rd(ISA_STATUS_OFS, 17'h10001);
    // rows past the target must not raise the flag again
    pulse(2);
    expect_rd(ISA_STATUS_OFS, 17'h10001);
    // a zero row field stands for a full 4096-row frame
    i_flush_row_count_word <= 16'h0000;
    i_expose_active <= 1'b0;
    @(posedge i_core_clk);
    i_expose_active <= 1'b1;
    repeat (4095) pulse(2);
    expect_rd(ISA_STATUS_OFS, 17'h10001);
    pulse(2);
    expect_rd(ISA_STATUS_OFS, 17'h10801);
    i_expose_active <= 1'b0;
    $display("test frame done");
  endtask

  task automatic t_mid_reset();
    pulse(0);
    @(posedge i_core_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    // the sticky line flag set before reset must be gone
    expect_rd(ISA_STATUS_OFS, 17'h10000);
    $display("test mid_reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_srst = 1'b1;
    i_pci_sel = 1'b0;
    i_command_word = 16'h0000;
    i_flush_row_count_word = 16'h0000;
    i_expose_active = 1'b0;
    i_line_done = 1'b0;
    i_cache_read_ok = 1'b0;
    i_temp_min_limit = 1'b0;
    i_temp_max_limit = 1'b0;
    i_shutdown_done = 1'b0;
    i_at_temp = 1'b0;
    i_ext_trigger_pin = 1'b0;
    i_row_flushed = 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_srst <= 1'b0;
    t_reset_map();
    t_levels();
    t_mirror();
    t_sticky();
    t_frame();
    t_mid_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
